// file: verification/host_port_model.sv
// Host serial port model that drives the selects, shift clock and data wire.
`timescale 1ns/1ns
module host_port_model (
  input  wire logic clock,
  input  wire logic data_out,
  input  wire logic data_out_oe_n,
  output logic      sck,
  output logic      sel_n,
  output logic      conv_n,
  output logic      line
);
  logic hd;
  logic hen;
  // The wire has no pull, so once released it shows the inverse bit.
  assign line = !data_out_oe_n ? data_out : (hen ? hd : !hd);
  initial begin
    sck = 1'b0;
    sel_n = 1'b1;
    conv_n = 1'b1;
    hd = 1'b0;
    hen = 1'b1;
  end
  // Six-clock half phases stay clear of the three-clock pin latency.
  task automatic half;
    repeat (6) @(negedge clock);
  endtask
  task automatic frame(input logic ms, input logic cs, input logic [5:0] w,
                       input int n, output logic [15:0] rx);
    hen = 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      hd = w[i];
      half();
      sck = 1'b1;
      half();
      sck = 1'b0;
    end
    sel_n = !ms;
    conv_n = !cs;
    hen = 1'b0;
    rx = 16'h0000;
    for (int k = 0; k <= 16; k++) begin
      half();
      sck = 1'b1;
      if (k > 0) rx = {rx[14:0], line};
      half();
      sck = 1'b0;
    end
    sel_n = 1'b1;
    conv_n = 1'b1;
    half();
  endtask
endmodule // host_port_model

// file: verification/mux_adc_serial_control_sva.sv
// Concurrent checks on the converter control block's ports.
`timescale 1ns/1ns
module mux_adc_serial_control_sva
  import mux_adc_pkg::*;
(
  input wire logic                clock,
  input wire logic                srst,
  input wire logic                shift_clock_pin,
  input wire logic                selector_select_n,
  input wire logic                converter_select_n,
  input wire logic                data_out,
  input wire logic                data_out_oe_n,
  input wire logic [CHANNELS-1:0] channel_on,
  input wire logic                converter_active,
  input wire logic                sample_track,
  input wire logic [RESULT_W-1:0] dac_code
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);
  sequence sel_fall;
    $fell(selector_select_n);
  endsequence
  a_break_gap: assert property (sel_fall |-> ##[1:12]
    channel_on == CHANNELS_OFF) else $error("channels not all off");
  a_one_hot: assert property ($onehot0(channel_on))
    else $error("more than one channel on");
  a_chan_stays: assert property (selector_select_n [*8] |->
    $stable(channel_on)) else $error("channel changed while select high");
  a_oe_idle: assert property (converter_select_n [*6] |->
    data_out_oe_n) else $error("output driven while select high");
  a_oe_drive: assert property (!converter_select_n [*6] |->
    !data_out_oe_n) else $error("wire not driven after select fall");
  a_dout_edge: assert property (!data_out_oe_n &&
    !$past(data_out_oe_n) && $changed(data_out) |-> !shift_clock_pin)
    else $error("output changed away from a falling edge");
  a_hold_start: assert property ($fell(sample_track) |->
    dac_code == DAC_MID_CODE && converter_active)
    else $error("hold did not start at mid code");
  a_power_down: assert property ($fell(sample_track) |->
    ##[1:300] !converter_active) else $error("converter stayed on");
endmodule // mux_adc_serial_control_sva

// file: verification/tb_mux_adc_serial_control.sv
// Self-checking bench for the converter control block.
`timescale 1ns/1ns
module tb_mux_adc_serial_control;
  import mux_adc_pkg::*;
  logic                clock = 1'b0;
  logic                srst = 1'b1;
  logic                cmp = 1'b0;
  logic                rdy = 1'b0;
  logic [RESULT_W-1:0] analog = 12'h000;
  logic [15:0]         rx;
  logic [RESULT_W-1:0] dac, rd;
  logic [CHANNELS-1:0] chan;
  logic                sck, sel_n, conv_n, line, dout, oe_n, act, rv, refd;
  logic                trk;
  int                  fails = 0;
  int                  cmp_count = 0;
  // Boundary codes first; nine results fill the buffer and its output stage.
  logic [RESULT_W-1:0] vals [9] = '{12'h000, 12'hFFF, 12'h800, 12'h7FF,
    12'h001, 12'hA5C, 12'h3C3, 12'hFFE, 12'h555};
  always #20 clock = ~clock;
  always @(negedge clock) cmp <= (analog >= dac);
  mux_adc_serial_control u_dut (.clock(clock), .srst(srst),
    .shift_clock_pin(sck), .selector_select_n(sel_n),
    .converter_select_n(conv_n), .data_in(line), .comparator_above(cmp),
    .result_ready(rdy), .data_out(dout), .data_out_oe_n(oe_n),
    .channel_on(chan), .converter_active(act), .sample_track(trk),
    .dac_code(dac), .conversion_refused(refd), .result_valid(rv),
    .result_data(rd));
  host_port_model u_host (.clock(clock), .data_out(dout),
    .data_out_oe_n(oe_n), .sck(sck), .sel_n(sel_n), .conv_n(conv_n),
    .line(line));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic conv(input logic ms, input logic [5:0] w, input int n,
                      input int i);
    analog = vals[i];
    u_host.frame(ms, 1'b1, w, n, rx);
    check(rx, {2'h0, vals[i], vals[i][1], vals[i][2]});
    check({13'h0, act, trk, oe_n}, 16'h0001);
  endtask
  task automatic t_select;
    for (int n = 0; n < CHANNELS; n++) begin
      // Odd channels carry two stale lead bits that must be dropped.
      conv(1'h1, {2'h1, 1'h1, 3'(n)}, (n % 2) ? 6 : 4, n);
      check(chan, 16'h0001 << n);
    end
  endtask
  task automatic t_repeat_refuse;
    conv(1'h0, 6'h00, 0, 8);
    check(chan, 16'h0080);
    analog = 12'hFFF;
    u_host.frame(1'h0, 1'h1, 6'h00, 0, rx);
    check(refd, 16'h0001);
    check(rx, 16'h0000);
  endtask
  task automatic t_drain;
    for (int i = 0; i < 9; i++) begin
      for (int w = 0; w < 8 && rv !== 1'b1; w++) @(negedge clock);
      check(rv, 16'h0001);
      check(rd, vals[i]);
      rdy = 1'b1;
      @(negedge clock);
      rdy = 1'b0;
    end
    repeat (4) @(negedge clock);
    check(rv, 16'h0000);
  endtask
  initial begin
    #400000;
    fails++;
    wrap_up();
  end
  initial begin
    repeat (2) @(negedge clock);
    srst = 1'b0;
    repeat (4) @(negedge clock);
    check({oe_n, act, rv, refd, dac}, 16'h8000);
    check(chan, 16'h0000);
    t_select();
    t_repeat_refuse();
    t_drain();
    u_host.frame(1'h1, 1'h0, 6'h07, 4, rx);
    check(chan, 16'h0000);
    wrap_up();
  end
endmodule // tb_mux_adc_serial_control
bind mux_adc_serial_control mux_adc_serial_control_sva u_sva (.clock,
  .srst, .shift_clock_pin, .selector_select_n, .converter_select_n,
  .data_out, .data_out_oe_n, .channel_on, .converter_active, .sample_track,
  .dac_code);

// file: verilog/mux_adc_pkg.sv
// Constants, types and state codes shared by the converter control block.
package mux_adc_pkg;

  localparam int CLOCK_NS            = 40;
  localparam int SWITCH_OFF_DELAY_NS = 200;
  localparam int SWITCH_ON_DELAY_NS  = 600;
  localparam int SWITCH_OFF_CYCLES   =
    (SWITCH_OFF_DELAY_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int SWITCH_ON_CYCLES    =
    (SWITCH_ON_DELAY_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int TIMER_W             = 8;

  localparam int CTRL_W      = 4;
  localparam int ADDR_W      = 3;
  localparam int CHANNELS    = 8;
  localparam int RESULT_W    = 12;
  localparam int FIFO_DEPTH  = 8;
  localparam int PIN_COUNT   = 5;

  localparam logic [1:0]          HOLD_EDGE_INDEX = 2'h1;
  localparam logic [3:0]          MSB_INDEX       = 4'hB;
  localparam logic [3:0]          LSB_FIRST_START = 4'h1;
  localparam logic [RESULT_W-1:0] DAC_MID_CODE    = 12'h800;
  localparam logic [RESULT_W-1:0] RESULT_RESET    = 12'h000;
  localparam logic [CTRL_W-1:0]   CTRL_RESET      = 4'h0;
  localparam logic [CHANNELS-1:0] CHANNELS_OFF    = 8'h00;
  localparam logic [PIN_COUNT-1:0] PIN_SYNC_RESET = 5'h06;

  typedef struct packed {
    logic              enable;
    logic [ADDR_W-1:0] addr;
  } control_word_t;

  typedef enum {
    CONV_IDLE,
    CONV_SAMPLE,
    CONV_RUN,
    CONV_LSB_FIRST,
    CONV_ZEROS
  } conv_state_t;

endpackage

// file: verilog/mux_adc_serial_control.sv
// Selector switching, serial port and conversion sequencer of the converter.
`timescale 1ns/1ns
module mux_adc_serial_control
  import mux_adc_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                srst,
  input  wire logic                shift_clock_pin,
  input  wire logic                selector_select_n,
  input  wire logic                converter_select_n,
  input  wire logic                data_in,
  input  wire logic                comparator_above,
  input  wire logic                result_ready,
  output logic                     data_out,
  output logic                     data_out_oe_n,
  output logic [CHANNELS-1:0]      channel_on,
  output logic                     converter_active,
  output logic                     sample_track,
  output logic [RESULT_W-1:0]      dac_code,
  output logic                     conversion_refused,
  output logic                     result_valid,
  output logic [RESULT_W-1:0]      result_data
);
  logic [PIN_COUNT-1:0] pin_raw;
  logic [PIN_COUNT-1:0] pin_meta;
  logic [PIN_COUNT-1:0] pin_sync;
  logic [PIN_COUNT-1:0] pin_prev;
  logic                 sclk_rise;
  logic                 sclk_fall;
  logic                 sel_high;
  logic                 sel_fall;
  logic                 conv_high;
  logic                 conv_fall;
  logic                 din_s;
  logic                 comp_s;
  logic [CTRL_W-1:0]    shift_word;
  control_word_t        applied;
  logic [TIMER_W-1:0]   switch_timer;
  conv_state_t          state;
  logic [1:0]           edge_count;
  logic [3:0]           bit_idx;
  logic [RESULT_W-1:0]  result;
  logic                 push_valid;
  logic [RESULT_W-1:0]  push_data;
  logic                 fifo_in_ready;

  assign pin_raw = {comparator_above, data_in, converter_select_n,
                    selector_select_n, shift_clock_pin};

  // Every pin crosses two flops; edges compare the second stage against a third flop.
  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_sync
    always_ff @(posedge clock) begin
      if (srst) begin
        pin_meta[i] <= PIN_SYNC_RESET[i];
        pin_sync[i] <= PIN_SYNC_RESET[i];
        pin_prev[i] <= PIN_SYNC_RESET[i];
      end else begin
        pin_meta[i] <= pin_raw[i];
        pin_sync[i] <= pin_meta[i];
        pin_prev[i] <= pin_sync[i];
      end
    end
  end

  assign sclk_rise = pin_sync[0] && !pin_prev[0];
  assign sclk_fall = !pin_sync[0] && pin_prev[0];
  assign sel_high  = pin_sync[1];
  assign sel_fall  = !pin_sync[1] && pin_prev[1];
  assign conv_high = pin_sync[2];
  assign conv_fall = !pin_sync[2] && pin_prev[2];
  assign din_s     = pin_sync[3];
  assign comp_s    = pin_sync[4];

  // Longer words simply push older bits out of the top.
  always_ff @(posedge clock) begin
    if (srst) begin
      shift_word <= CTRL_RESET;
    end else if (sel_high && sclk_rise) begin
      shift_word <= {shift_word[CTRL_W-2:0], din_s};
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      applied <= CTRL_RESET;
    end else if (sel_fall) begin
      applied <= shift_word;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      switch_timer <= TIMER_W'(SWITCH_ON_CYCLES);
    end else if (sel_fall) begin
      switch_timer <= '0;
    end else if (switch_timer != TIMER_W'(SWITCH_ON_CYCLES)) begin
      switch_timer <= switch_timer + 1'b1;
    end
  end

  // Old channel stays on until the off delay, giving the open gap.
  always_ff @(posedge clock) begin
    if (srst) begin
      channel_on <= CHANNELS_OFF;
    end else if (switch_timer == TIMER_W'(SWITCH_OFF_CYCLES - 1)) begin
      channel_on <= CHANNELS_OFF;
    end else if (switch_timer == TIMER_W'(SWITCH_ON_CYCLES - 1)) begin
      if (applied.enable) begin
        channel_on <= CHANNELS'(1) << applied.addr;
      end else begin
        channel_on <= CHANNELS_OFF;
      end
    end
  end

  // A full buffer refuses the conversion rather than lose a result.
  always_ff @(posedge clock) begin
    if (srst || conv_high) begin
      state <= CONV_IDLE;
    end else if (conv_fall) begin
      state <= fifo_in_ready ? CONV_SAMPLE : CONV_ZEROS;
    end else if (sclk_fall) begin
      case (state)
        CONV_SAMPLE: begin
          if (edge_count == HOLD_EDGE_INDEX) begin
            state <= CONV_RUN;
          end
        end
        CONV_RUN: begin
          if (bit_idx == '0) begin
            state <= CONV_LSB_FIRST;
          end
        end
        CONV_LSB_FIRST: begin
          if (bit_idx == MSB_INDEX) begin
            state <= CONV_ZEROS;
          end
        end
        CONV_ZEROS: state <= CONV_ZEROS;
        default:    state <= CONV_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst || conv_fall) begin
      edge_count <= '0;
    end else if (sclk_fall && state == CONV_SAMPLE) begin
      edge_count <= edge_count + 2'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      conversion_refused <= 1'b0;
    end else if (conv_fall) begin
      conversion_refused <= !fifo_in_ready;
    end
  end

  // Successive approximation: one decision per falling shift edge.
  always_ff @(posedge clock) begin
    if (srst) begin
      dac_code <= RESULT_RESET;
      bit_idx  <= MSB_INDEX;
      result   <= RESULT_RESET;
    end else if (sclk_fall) begin
      case (state)
        CONV_SAMPLE: begin
          if (edge_count == HOLD_EDGE_INDEX) begin
            dac_code <= DAC_MID_CODE;
            bit_idx  <= MSB_INDEX;
          end
        end
        CONV_RUN: begin
          dac_code[bit_idx] <= comp_s;
          if (bit_idx != '0) begin
            dac_code[bit_idx - 4'h1] <= 1'b1;
            bit_idx <= bit_idx - 4'h1;
          end else begin
            result  <= {dac_code[RESULT_W-1:1], comp_s};
            bit_idx <= LSB_FIRST_START;
          end
        end
        CONV_LSB_FIRST: bit_idx <= bit_idx + 4'h1;
        default: bit_idx <= bit_idx;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      push_valid <= 1'b0;
      push_data  <= RESULT_RESET;
    end else begin
      push_valid <= sclk_fall && state == CONV_RUN && bit_idx == '0;
      push_data  <= {dac_code[RESULT_W-1:1], comp_s};
    end
  end

  always_ff @(posedge clock) begin
    if (srst || conv_high) begin
      data_out <= 1'b0;
    end else if (conv_fall) begin
      data_out <= 1'b0;
    end else if (sclk_fall) begin
      case (state)
        CONV_RUN:       data_out <= comp_s;
        CONV_LSB_FIRST: data_out <= result[bit_idx];
        default:        data_out <= 1'b0;
      endcase
    end
  end

  // Driving at once on select fall keeps well ahead of the sixth edge.
  always_ff @(posedge clock) begin
    if (srst || conv_high) begin
      data_out_oe_n <= 1'b1;
    end else if (conv_fall) begin
      data_out_oe_n <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst || conv_high) begin
      converter_active <= 1'b0;
    end else if (conv_fall) begin
      converter_active <= fifo_in_ready;
    end else if (sclk_fall && state == CONV_RUN && bit_idx == '0) begin
      converter_active <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst || conv_high) begin
      sample_track <= 1'b0;
    end else if (conv_fall) begin
      sample_track <= fifo_in_ready;
    end else if (sclk_fall && state == CONV_SAMPLE
                 && edge_count == HOLD_EDGE_INDEX) begin
      sample_track <= 1'b0;
    end
  end

  result_fifo #(
    .WIDTH (RESULT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .srst      (srst),
    .in_valid  (push_valid),
    .in_data   (push_data),
    .in_ready  (fifo_in_ready),
    .out_valid (result_valid),
    .out_data  (result_data),
    .out_ready (result_ready)
  );
endmodule // mux_adc_serial_control

// Result buffer with a registered output stage.
module result_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wptr;
  logic [PW-1:0]    rptr;
  logic [CW-1:0]    count;
  logic             push;
  logic             pop;

  assign in_ready = (count != FULL);
  assign push     = in_valid && in_ready;
  assign pop      = (count != '0) && (!out_valid || out_ready);

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wptr] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (push) begin
        wptr <= (wptr == LAST) ? '0 : wptr + 1'b1;
      end
      if (pop) begin
        rptr <= (rptr == LAST) ? '0 : rptr + 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      count <= '0;
    end else if (push && !pop) begin
      count <= count + 1'b1;
    end else if (pop && !push) begin
      count <= count - 1'b1;
    end
  end

  // The output stage adds one word of room beyond DEPTH.
  always_ff @(posedge clock) begin
    if (srst) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data  <= mem[rptr];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule // result_fifo

// file: verilog/result_fifo.sv
// The result buffer module sits beside the control logic that feeds it.
